// ==== verilog/rsc_consts.vh ====
// Constants for the reset and stop-release controller.
// Assumes inclusion by bare name from the design files under verilog/.
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// Register offsets, byte addresses on a 32-bit Wishbone bus.
`define RSC_ADR_CTRL 6'h00
`define RSC_ADR_STAT 6'h04
`define RSC_ADR_VEC 6'h08
`define RSC_ADR_IRQ 6'h0c
`define RSC_ADR_PORT 6'h10
`define RSC_ADR_CLK 6'h14
`define RSC_ADR_MEM 6'h18
`define RSC_ADR_TMR 6'h1c
`define RSC_ADR_SER 6'h20
`define RSC_ADR_WIDTH 6

// Documented reset values.
`define RSC_PSW_RST 8'h02
`define RSC_PORT_LATCH_RST 8'h00
`define RSC_PORT_DIR_RST 8'hff
`define RSC_PULLUP_RST 8'h00
`define RSC_CPU_CLK_RST 8'h04
`define RSC_OSC_SETTLE_RST 8'h04
`define RSC_MEM_WAIT_RST 8'h10
`define RSC_MEM_MODE_RST 8'h00
`define RSC_MEM_SIZE_RST 8'hcf
`define RSC_WIDE_TMR_RST 16'h0000
`define RSC_BYTE_CLR 8'h00
`define RSC_IRQ_FLAG_RST 8'h00
`define RSC_IRQ_MASK_RST 8'hff
`define RSC_IRQ_PRIO_RST 8'hff
`define RSC_EDGE_RST 8'h00
`define RSC_UART_TX_RST 8'hff

// Reset vector addresses, low byte first.
`define RSC_VEC_LO_ADR 16'h0000
`define RSC_VEC_HI_ADR 16'h0001

// Settle wait is two to this power main-clock periods.
`define RSC_SETTLE_EXP 17

// Control register bit positions.
`define RSC_CTRL_STOP 0
`define RSC_CTRL_STANDBY 1
`define RSC_CTRL_GIE 2
`define RSC_CTRL_IN_SERVICE 3

// Least external reset pulse, in nanoseconds, and clock period.
`define RSC_EXT_RST_MIN_NS 10000
`define RSC_CLK_PERIOD_NS 50

`endif

// ==== verilog/rsc_vec_mem.v ====
// Holds the two reset vector bytes and the retained data memory.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/1ps
module rsc_vec_mem #(
  parameter AW = 4,
  parameter DW = 8
) (
  // Clock.
  input wire clk_i,
  // Write port.
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  // Read port.
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  // The array has no reset, so reset never disturbs its contents.
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end

endmodule

// ==== verilog/rsc_reset_ctrl.v ====
// Reset and stop-release controller of a small 8-bit controller core.
// Assumes one 20 MHz clock, a synchronous high reset for the logic, and
// a Wishbone classic master; the pin reset is synchronous to clk_i.
// Function
// - Reset during deep stop ends the stop, then waits the settle time.
// - Unmasked wake vectors only if acknowledgeable, else runs next instruction.
// - A masked request keeps the device in deep stop.
// - Pin reset and watchdog overflow produce the same reset.
// - After reset the pointer loads from the vector at addresses zero and one.
// - All pins float during reset and the settle wait.
// - After pin release wait two to the seventeen main-clock periods.
// - Watchdog reset releases itself and uses the same settle wait.
// - Main oscillator stops during reset; subsystem oscillator keeps running.
// - Reset out of deep stop keeps the stop state while pins float; the code clears it at release, before the settle wait.
// - Status word resets to 02h; data memory and work registers untouched.
// - Only the instruction pointer goes undefined during reset and wait.
// - Reset in standby keeps data memory and work registers.
// - Port latches and pull-ups clear; direction registers set to inputs.
// - Clock control and settle select 04h, wait 10h, expansion mode 00h.
// - Memory size select resets to CFh; software rewrites it.
// - Wide timer and eight-bit timers with their controls clear.
// - Request flags and edge enables clear; masks and priorities set.
// - UART transmit shifter FFh; other serial and analog controls clear.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "rsc_consts.vh"
module rsc_reset_ctrl #(
  parameter SETTLE_CYCLES = (1 << `RSC_SETTLE_EXP),
  parameter CNT_W = 18,
  parameter MEM_AW = 4
) (
  // Clock and logic reset.
  input wire clk_i,
  input wire rst_i,
  // Reset sources, the pin low-active.
  input wire ext_reset_n_i,
  input wire wdt_overflow_i,
  // Interrupt request seen by the stop release logic.
  input wire irq_req_i,
  input wire [2:0] irq_src_i,
  // Wishbone classic slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`RSC_ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Core and pin control.
  output reg cpu_run_o,
  output reg [15:0] instruction_pointer_o,
  output reg pins_oe_n_o,
  output reg main_osc_en_o,
  output reg sub_osc_en_o,
  output reg irq_vector_o,
  output reg next_instr_o,
  output reg in_stop_o
);

  // ==========================================================
  // State encoding
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_RESET = 4'h2;
  localparam [3:0] ST_SETTLE = 4'h4;
  localparam [3:0] ST_VECTOR = 4'h8;

  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_CYCLES - 1;

  reg [3:0] state_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg stop_reg, standby_reg, gie_reg, in_service_priority_flag, from_stop_reg, vec_phase_reg;
  reg [7:0] vec_lo_reg, processor_status_word, port_latch_reg, port_direction_reg, pullup_option_reg;
  reg [7:0] cpu_clock_control, osc_settle_select, mem_wait_reg, mem_mode_reg, memory_size_select;
  reg [15:0] wide_timer_count;
  reg [7:0] timer_ctrl_reg, irq_request_flags, irq_mask_flags, irq_priority_flags;
  reg [7:0] rising_edge_enable, falling_edge_enable, uart_tx_shifter, serial_ctrl_reg;

  // ==========================================================
  // Reset merge
  // Both sources feed one request, so they behave alike.
  wire reset_req = ~ext_reset_n_i | wdt_overflow_i;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master samples ack high.
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire mask_bit = irq_mask_flags[irq_src_i];
  wire prio_bit = irq_priority_flags[irq_src_i];
  wire wake = irq_req_i & ~mask_bit;
  // A clear priority flag needs only the enable; a set one also needs no high service.
  wire ackable = prio_bit ? (gie_reg & in_service_priority_flag) : gie_reg;

  // Vector memory: address picked by fetch phase, cut to the memory width.
  wire [7:0] vec_rdata;
  wire [15:0] vec_adr = vec_phase_reg ? `RSC_VEC_HI_ADR : `RSC_VEC_LO_ADR;
  wire [MEM_AW-1:0] mem_raddr = vec_adr[MEM_AW-1:0];
  wire mem_we = bus_wr & (wb_adr_i == `RSC_ADR_VEC);

  rsc_vec_mem #(
    .AW(MEM_AW),
    .DW(8)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(wb_dat_i[8 +: MEM_AW]),
    .wdata_i(wb_dat_i[7:0]),
    .raddr_i(mem_raddr),
    .rdata_o(vec_rdata)
  );

  // ==========================================================
  // Sequencer
  // Reset holds; release starts the settle count, then fetches the vector.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_RESET;
      cnt_reg <= {CNT_W{1'b0}};
      stop_reg <= 1'b0;
      from_stop_reg <= 1'b0;
      vec_phase_reg <= 1'b0;
      vec_lo_reg <= 8'h00;
      instruction_pointer_o <= 16'h0000;
      cpu_run_o <= 1'b0;
      pins_oe_n_o <= 1'b1;
      main_osc_en_o <= 1'b0;
      sub_osc_en_o <= 1'b1;
      irq_vector_o <= 1'b0;
      next_instr_o <= 1'b0;
      in_stop_o <= 1'b0;
    end
    else
    begin
      irq_vector_o <= 1'b0;
      next_instr_o <= 1'b0;
      sub_osc_en_o <= 1'b1;
      case (state_reg)
        ST_RUN:
        begin
          if (reset_req)
          begin
            // Stop ends; the stop flag is kept during reset itself.
            from_stop_reg <= stop_reg;
            state_reg <= ST_RESET;
            cpu_run_o <= 1'b0;
            pins_oe_n_o <= 1'b1;
            main_osc_en_o <= 1'b0;
          end
          else if (stop_reg)
          begin
            if (wake)
            begin
              stop_reg <= 1'b0;
              cnt_reg <= {CNT_W{1'b0}};
              main_osc_en_o <= 1'b1;
              state_reg <= ST_SETTLE;
              from_stop_reg <= 1'b1;
            end
          end
          else if (bus_wr & (wb_adr_i == `RSC_ADR_CTRL) & wb_dat_i[`RSC_CTRL_STOP])
          begin
            stop_reg <= 1'b1;
            cpu_run_o <= 1'b0;
            main_osc_en_o <= 1'b0;
          end
        end
        ST_RESET:
        begin
          cpu_run_o <= 1'b0;
          pins_oe_n_o <= 1'b1;
          main_osc_en_o <= 1'b0;
          cnt_reg <= {CNT_W{1'b0}};
          if (!reset_req)
          begin
            // Pin or watchdog released: both go to the same wait.
            main_osc_en_o <= 1'b1;
            stop_reg <= 1'b0;
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE:
        begin
          if (reset_req)
          begin
            state_reg <= ST_RESET;
            main_osc_en_o <= 1'b0;
            pins_oe_n_o <= 1'b1;
          end
          else if (cnt_reg == SETTLE_LAST)
          begin
            cnt_reg <= {CNT_W{1'b0}};
            vec_phase_reg <= 1'b0;
            if (from_stop_reg & ~pins_oe_n_o)
            begin
              // Interrupt wake: vector or continue.
              state_reg <= ST_RUN;
              cpu_run_o <= 1'b1;
              irq_vector_o <= ackable;
              next_instr_o <= ~ackable;
            end
            else
            begin
              state_reg <= ST_VECTOR;
            end
          end
          else
          begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_VECTOR:
        begin
          // Two-byte fetch; the memory answers one cycle late.
          cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          if (reset_req)
          begin
            // A reset during the fetch wins, so the core never starts in reset.
            state_reg <= ST_RESET;
            main_osc_en_o <= 1'b0;
          end
          else if (cnt_reg[1:0] == 2'b00)
          begin
            vec_phase_reg <= 1'b1;
          end
          else if (cnt_reg[1:0] == 2'b01)
          begin
            vec_lo_reg <= vec_rdata;
          end
          else
          begin
            instruction_pointer_o <= {vec_rdata, vec_lo_reg};
            vec_phase_reg <= 1'b0;
            cnt_reg <= {CNT_W{1'b0}};
            from_stop_reg <= 1'b0;
            cpu_run_o <= 1'b1;
            pins_oe_n_o <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        default:
        begin
          state_reg <= ST_RESET;
        end
      endcase
      in_stop_o <= stop_reg;
    end
  end

  // ==========================================================
  // Peripheral reset values and register writes
  // Logic reset and every cycle in ST_RESET load defaults; settle changes nothing else.
  wire apply_rst = rst_i | (state_reg == ST_RESET);

  always @(posedge clk_i)
  begin
    if (apply_rst)
    begin
      processor_status_word <= `RSC_PSW_RST;
      port_latch_reg <= `RSC_PORT_LATCH_RST;
      port_direction_reg <= `RSC_PORT_DIR_RST;
      pullup_option_reg <= `RSC_PULLUP_RST;
      cpu_clock_control <= `RSC_CPU_CLK_RST;
      osc_settle_select <= `RSC_OSC_SETTLE_RST;
      mem_wait_reg <= `RSC_MEM_WAIT_RST;
      mem_mode_reg <= `RSC_MEM_MODE_RST;
      memory_size_select <= `RSC_MEM_SIZE_RST;
      wide_timer_count <= `RSC_WIDE_TMR_RST;
      timer_ctrl_reg <= `RSC_BYTE_CLR;
      irq_request_flags <= `RSC_IRQ_FLAG_RST;
      irq_mask_flags <= `RSC_IRQ_MASK_RST;
      irq_priority_flags <= `RSC_IRQ_PRIO_RST;
      rising_edge_enable <= `RSC_EDGE_RST;
      falling_edge_enable <= `RSC_EDGE_RST;
      uart_tx_shifter <= `RSC_UART_TX_RST;
      serial_ctrl_reg <= `RSC_BYTE_CLR;
      gie_reg <= 1'b0;
      in_service_priority_flag <= 1'b1;
      standby_reg <= 1'b0;
    end
    else
    begin
      if (bus_wr)
      begin
        case (wb_adr_i)
          `RSC_ADR_CTRL:
          begin
            standby_reg <= wb_dat_i[`RSC_CTRL_STANDBY];
            gie_reg <= wb_dat_i[`RSC_CTRL_GIE];
            in_service_priority_flag <= wb_dat_i[`RSC_CTRL_IN_SERVICE];
            processor_status_word <= wb_dat_i[15:8];
          end
          `RSC_ADR_IRQ:
          begin
            irq_mask_flags <= wb_dat_i[15:8];
            irq_priority_flags <= wb_dat_i[23:16];
          end
          `RSC_ADR_PORT:
          begin
            port_latch_reg <= wb_dat_i[7:0];
            port_direction_reg <= wb_dat_i[15:8];
            pullup_option_reg <= wb_dat_i[23:16];
          end
          `RSC_ADR_CLK:
          begin
            cpu_clock_control <= wb_dat_i[7:0];
            osc_settle_select <= wb_dat_i[15:8];
          end
          `RSC_ADR_MEM:
          begin
            mem_wait_reg <= wb_dat_i[7:0];
            mem_mode_reg <= wb_dat_i[15:8];
            memory_size_select <= wb_dat_i[23:16];
          end
          `RSC_ADR_SER:
          begin
            uart_tx_shifter <= wb_dat_i[7:0];
            serial_ctrl_reg <= wb_dat_i[15:8];
          end
          default: timer_ctrl_reg <= timer_ctrl_reg;
        endcase
      end
      // Request flags latch new requests; a set beats a same-cycle clear.
      if (bus_wr & (wb_adr_i == `RSC_ADR_IRQ))
      begin
        irq_request_flags <= (irq_request_flags & ~wb_dat_i[7:0]) | ({7'h00, irq_req_i} << irq_src_i);
      end
      else if (irq_req_i)
      begin
        irq_request_flags <= irq_request_flags | ({7'h00, 1'b1} << irq_src_i);
      end
    end
  end

  // ==========================================================
  // Wishbone read and acknowledge
  // One registered ack per request, the cycle after it; unmapped reads return zero.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          `RSC_ADR_CTRL: wb_dat_o <= {16'h0000, processor_status_word, 4'h0, in_service_priority_flag, gie_reg,
                                     standby_reg, stop_reg};
          `RSC_ADR_STAT: wb_dat_o <= {12'h000, state_reg, instruction_pointer_o};
          `RSC_ADR_IRQ: wb_dat_o <= {8'h00, irq_priority_flags, irq_mask_flags, irq_request_flags};
          `RSC_ADR_PORT: wb_dat_o <= {8'h00, pullup_option_reg, port_direction_reg, port_latch_reg};
          `RSC_ADR_CLK: wb_dat_o <= {16'h0000, osc_settle_select, cpu_clock_control};
          `RSC_ADR_MEM: wb_dat_o <= {8'h00, memory_size_select, mem_mode_reg, mem_wait_reg};
          `RSC_ADR_TMR: wb_dat_o <= {8'h00, timer_ctrl_reg, wide_timer_count};
          `RSC_ADR_SER: wb_dat_o <= {16'h0000, serial_ctrl_reg, uart_tx_shifter};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ==== dv/rsc_properties.sv ====
// Concurrent checks on the ports of the reset and stop-release controller.
// Assumes it is bound to rsc_reset_ctrl, one clock, synchronous high reset.
`timescale 1ns/1ps
module rsc_properties #(
  parameter SETTLE_CYCLES = 16
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Reset sources.
  input wire ext_reset_n_i,
  input wire wdt_overflow_i,
  // Bus handshake.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Core and pin control.
  input wire cpu_run_o,
  input wire pins_oe_n_o,
  input wire main_osc_en_o,
  input wire sub_osc_en_o,
  input wire irq_vector_o,
  input wire next_instr_o
);
  localparam int RUN_HI = SETTLE_CYCLES + 8;
  reg [9:0] quiet_cnt_reg;
  wire src_on = !ext_reset_n_i || wdt_overflow_i;
  // ==========================================
  // Cycles since the last reset source, saturating so it never wraps.
  always @(posedge clk_i)
  begin
    if (rst_i || src_on)
      quiet_cnt_reg <= 10'h000;
    else if (quiet_cnt_reg != 10'h3ff)
      quiet_cnt_reg <= quiet_cnt_reg + 10'h001;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_src;
    src_on;
  endsequence
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // ==========================================
  // Properties.
  a_pins_float: assert property (s_src |=> pins_oe_n_o)
    else $error("pins driven while a reset source is active");
  a_float_idle: assert property (pins_oe_n_o |-> !cpu_run_o)
    else $error("core runs while pins float");
  a_main_osc_off: assert property (s_src |=> !main_osc_en_o)
    else $error("main oscillator runs during reset");
  a_sub_osc_on: assert property (sub_osc_en_o)
    else $error("subsystem oscillator stopped");
  a_settle_min: assert property ($rose(cpu_run_o) |-> quiet_cnt_reg >= SETTLE_CYCLES)
    else $error("core started before the settle wait");
  a_start_bound: assert property (quiet_cnt_reg == RUN_HI |-> cpu_run_o)
    else $error("core not started after the settle wait");
  a_wake_excl: assert property (!(irq_vector_o && next_instr_o))
    else $error("vector and next instruction together");
  a_wake_pulse: assert property (irq_vector_o || next_instr_o |=> !irq_vector_o && !next_instr_o)
    else $error("wake pulse longer than one cycle");
  a_ack_reply: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule

// ==== dv/rsc_src_model.sv ====
// Model of the board reset driver and the on-chip watchdog overflow.
// Assumes the bench calls its tasks in the clk_i domain.
`timescale 1ns/1ps
module rsc_src_model #(
  parameter MIN_LOW = 200
) (
  // Clock.
  input wire clk_i,
  // Reset sources.
  output reg ext_reset_n_o,
  output reg wdt_overflow_o
);
  int low_cnt;
  // Idle levels from time zero.
  initial
  begin
    ext_reset_n_o = 1'b1;
    wdt_overflow_o = 1'b0;
    low_cnt = 0;
  end
  // Counts how long the pin has been low.
  always @(posedge clk_i)
    low_cnt <= ext_reset_n_o ? 0 : low_cnt + 1;
  // Pulls the pin low.
  task pin_low();
  begin
    @(posedge clk_i);
    ext_reset_n_o <= 1'b0;
  end
  endtask
  // Releases the pin, never before the least low time of ten microseconds.
  task pin_high();
  begin
    @(posedge clk_i);
    while (low_cnt < MIN_LOW)
      @(posedge clk_i);
    ext_reset_n_o <= 1'b1;
  end
  endtask
  // Raises an overflow for n cycles.
  task wdt_fire(input int n);
  begin
    @(posedge clk_i);
    wdt_overflow_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    wdt_overflow_o <= 1'b0;
  end
  endtask
endmodule

// ==== dv/rsc_reset_ctrl_test.sv ====
// Self-checking bench for the reset and stop-release controller.
// Assumes the design under verilog/ and the checker and source model under dv/.
`timescale 1ns/1ps
`include "rsc_consts.vh"
module rsc_reset_ctrl_test;
  localparam int SETTLE = 16;
  // Wake rows: {priority, enable, in-service, expect vector}.
  logic [3:0] rows [5] = '{4'h2, 4'h5, 4'ha, 4'hc, 4'hf};
  logic clk_i, rst_i, irq_req_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic ext_reset_n_i, wdt_overflow_i, cpu_run_o, pins_oe_n_o, in_stop_o;
  logic main_osc_en_o, sub_osc_en_o, irq_vector_o, next_instr_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] instruction_pointer_o;
  int err_count, checks_done, n;
  rsc_reset_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ext_reset_n_i(ext_reset_n_i), .wdt_overflow_i(wdt_overflow_i), .irq_req_i(irq_req_i),
    .irq_src_i(3'h5), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cpu_run_o(cpu_run_o), .instruction_pointer_o(instruction_pointer_o),
    .pins_oe_n_o(pins_oe_n_o), .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
    .irq_vector_o(irq_vector_o), .next_instr_o(next_instr_o), .in_stop_o(in_stop_o));
  rsc_src_model i_src (.clk_i(clk_i), .ext_reset_n_o(ext_reset_n_i), .wdt_overflow_o(wdt_overflow_i));
  // ==========================================
  // Tasks.
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  end
  endtask
  // One classic cycle, held until ack is sampled high.
  task wb(input logic we, input logic [5:0] adr, input logic [31:0] dat);
  int k;
  begin
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 50)
      chk("bus ack", 1, 0);
  end
  endtask
  // Counts cycles until the core runs, then checks the start state.
  task start_chk();
  begin
    n = 0;
    while (cpu_run_o !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("settle min", 1, n >= SETTLE);
    chk("settle max", 1, n <= SETTLE + 8);
    chk("pointer", 32'h1234, instruction_pointer_o);
    chk("pins driven", 0, pins_oe_n_o);
    wb(0, `RSC_ADR_IRQ, 0);
    chk("irq regs", 32'h00ffff00, rd & 32'h00ffffff);
    wb(0, `RSC_ADR_PORT, 0);
    chk("port regs", 32'h0000ff00, rd);
    wb(0, `RSC_ADR_CLK, 0);
    chk("clock regs", 32'h00000404, rd);
    wb(0, `RSC_ADR_MEM, 0);
    chk("memory regs", 32'h00cf0010, rd);
    wb(0, `RSC_ADR_SER, 0);
    chk("serial regs", 32'h000000ff, rd);
  end
  endtask
  task stop_test();
  begin
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // ==========================================
  // Clock and watchdog.
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    stop_test();
  end
  // ==========================================
  // Main sequence.
  initial
  begin
    {rst_i, irq_req_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `RSC_ADR_CTRL, 0);
    chk("status word", 32'h02, rd[15:8]);
    wb(0, 6'h3c, 0);
    chk("unmapped", 0, rd);
    wb(1, `RSC_ADR_VEC, 32'h034);
    wb(1, `RSC_ADR_VEC, 32'h112);
    // Non-default values, so the next reset has something to restore.
    wb(1, `RSC_ADR_PORT, 32'h5aa5c3);
    wb(1, `RSC_ADR_CLK, 32'h0102);
    wb(1, `RSC_ADR_SER, 32'h3c5a);
    wb(1, `RSC_ADR_MEM, 32'h00c80312);
    wb(0, `RSC_ADR_MEM, 0);
    chk("size rewrite", 32'h00c80312, rd);
    wb(1, `RSC_ADR_IRQ, 32'hff);
    i_src.pin_low();
    repeat (3) @(posedge clk_i);
    chk("float", 1, pins_oe_n_o);
    chk("main osc", 0, main_osc_en_o);
    chk("sub osc", 1, sub_osc_en_o);
    i_src.pin_high();
    start_chk();
    wb(1, `RSC_ADR_IRQ, 32'hff);
    i_src.wdt_fire(5);
    start_chk();
    i_src.wdt_fire(3);
    repeat (SETTLE / 2) @(posedge clk_i);
    i_src.wdt_fire(3);
    start_chk();
    wb(1, `RSC_ADR_CTRL, 32'h0201);
    repeat (3) @(posedge clk_i);
    irq_req_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("masked hold", 1, in_stop_o);
    chk("masked run", 0, cpu_run_o);
    irq_req_i <= 1'b0;
    i_src.pin_low();
    repeat (3) @(posedge clk_i);
    chk("stop kept", 1, in_stop_o);
    chk("stop float", 1, pins_oe_n_o);
    i_src.pin_high();
    start_chk();
    chk("stop left", 0, in_stop_o);
    // Wake from stop through each acknowledge case.
    for (int i = 0; i < 5; i++)
    begin
      wb(1, `RSC_ADR_IRQ, {8'h0, rows[i][3] ? 8'h20 : 8'h00, 8'hdf, 8'hff});
      wb(1, `RSC_ADR_CTRL, {16'h0, 8'h02, 4'h0, rows[i][1], rows[i][2], 2'b01});
      repeat (3) @(posedge clk_i);
      irq_req_i <= 1'b1;
      n = 0;
      while (irq_vector_o !== 1'b1 && next_instr_o !== 1'b1 && n < 400)
      begin
        @(posedge clk_i);
        n++;
      end
      chk("wake vector", rows[i][0], irq_vector_o);
      chk("wake next", !rows[i][0], next_instr_o);
      irq_req_i <= 1'b0;
    end
    stop_test();
  end
endmodule
bind rsc_reset_ctrl rsc_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props (.clk_i(clk_i),
  .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i), .wdt_overflow_i(wdt_overflow_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_run_o(cpu_run_o),
  .pins_oe_n_o(pins_oe_n_o), .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
  .irq_vector_o(irq_vector_o), .next_instr_o(next_instr_o));
